// ===== sim/host_mem.sv
// Host memory model answering the bus DMA cycles of the word DMA interface.
// Assumes request, sync and address change only on clk; slow and mute come from the bench.
`timescale 1ns/100ps
module host_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mute,
  input wire logic dreq,
  output logic dgnt,
  input wire logic dsync,
  input wire logic dwr,
  input wire logic [15:0] daddr,
  input wire logic [15:0] dwdata,
  output logic [15:0] drdata,
  output logic drep
);
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;
  logic [15:0] last_q;
  // Data lines turn over once the reply is gone, so a late sample never passes
  assign drdata = drep ? mem[daddr[8:1]] : ~last_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dgnt <= 1'b0;
      drep <= 1'b0;
      wait_q <= 4'h0;
      last_q <= 16'h0000;
    end
    else
    begin
      dgnt <= dreq;
      wait_q <= dsync ? wait_q + 4'h1 : 4'h0;
      // Mute leaves the location silent to provoke the reply timeout
      drep <= dsync && !mute && (wait_q >= (slow ? 4'h6 : 4'h1));
      if (drep)
        last_q <= drdata;
      if (drep && dwr)
        mem[daddr[8:1]] <= dwdata;
    end
  end
endmodule : host_mem

// ===== sim/word_dma_interface_control_tb.sv
// Self-checking bench for the word DMA interface controller.
// Assumes host_mem as the bus memory and a short reply timeout for speed.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("FAIL %0t got %h want %h", $time, (a), (b)); end end
`define WAITV(s, v) begin repeat (200) if ((s) !== (v)) begin @(posedge REF_CLK); #1; end \
  if ((s) !== (v)) begin bad_count++; $display("FAIL %0t wait timed out", $time); end end
module word_dma_interface_control_tb;
  import wdma_pkg::*;
  logic REF_CLK = 0, RESETN = 0, BUS_INIT = 0, REG_RD = 0, REG_WR = 0;
  logic [1:0] REG_SEL = 0, REG_BE = 0;
  logic [15:0] REG_WDATA = 0, REG_RDATA, DMA_ADDR, DMA_WDATA, DMA_RDATA, OUT_DATA;
  logic [15:0] IN_DATA = 0, d;
  logic REG_ACK, DMA_REQ, DMA_GRANT, DMA_SYNC, DMA_WRITE, DMA_REPLY, IRQ_REQ;
  logic IRQ_GRANT = 0, IN_AVAIL = 0, OUT_ACCEPT = 0, EARLY_END = 0, SENSE_IN = 1;
  logic OUT_VALID, OUT_LAST, USER_SIGNAL_N, slow = 0, mute = 0;
  logic [2:0] IRQ_LEVEL;
  int bad_count = 0, samples_checked = 0;
  always #12.5 REF_CLK = ~REF_CLK;
  word_dma_ctl #(.REPLY_CYCLES(20)) dut (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .BUS_INIT(BUS_INIT), .REG_SEL(REG_SEL), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .REG_BE(REG_BE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
    .DMA_REQ(DMA_REQ), .DMA_GRANT(DMA_GRANT), .DMA_SYNC(DMA_SYNC), .DMA_WRITE(DMA_WRITE),
    .DMA_ADDR(DMA_ADDR), .DMA_WDATA(DMA_WDATA), .DMA_RDATA(DMA_RDATA),
    .DMA_REPLY(DMA_REPLY), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
    .IRQ_GRANT(IRQ_GRANT), .IN_DATA(IN_DATA), .IN_AVAIL(IN_AVAIL),
    .OUT_ACCEPT(OUT_ACCEPT), .EARLY_END(EARLY_END), .SENSE_IN(SENSE_IN),
    .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .OUT_LAST(OUT_LAST),
    .USER_SIGNAL_N(USER_SIGNAL_N));
  host_mem host (.clk(REF_CLK), .rst_n(RESETN), .slow(slow), .mute(mute),
    .dreq(DMA_REQ), .dgnt(DMA_GRANT), .dsync(DMA_SYNC), .dwr(DMA_WRITE),
    .daddr(DMA_ADDR), .dwdata(DMA_WDATA), .drdata(DMA_RDATA), .drep(DMA_REPLY));
  //////////////////////////////////////////////////////////////////////////////
  task automatic reg_op(input logic wr, input logic [1:0] sel, input logic [1:0] be,
    input logic [15:0] wd);
    @(posedge REF_CLK);
    #1;
    REG_SEL = sel;
    REG_BE = be;
    REG_WDATA = wd;
    REG_WR = wr;
    REG_RD = !wr;
    @(posedge REF_CLK);
    #1;
    REG_WR = 0;
    REG_RD = 0;
    `WAITV(REG_ACK, 1'b1)
    d = REG_RDATA;
  endtask : reg_op
  task automatic grant_irq();
    `WAITV(IRQ_REQ, 1'b1)
    IRQ_GRANT = 1;
    @(posedge REF_CLK);
    #1;
    IRQ_GRANT = 0;
    repeat (2) @(posedge REF_CLK);
    #1;
  endtask : grant_irq
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(25 * 30000);
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge REF_CLK);
    #1;
    RESETN = 1;
    BUS_INIT = 1;
    @(posedge REF_CLK);
    #1;
    BUS_INIT = 0;
    repeat (6) @(posedge REF_CLK);
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d, 16'h0188)
    `CHK(IRQ_LEVEL, 3'h5)
    reg_op(1, 2'h2, 2'h1, 16'h0074);
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d, 16'h01cc)
    `CHK(USER_SIGNAL_N, 1'b0)
    BUS_INIT = 1;
    @(posedge REF_CLK);
    #1;
    BUS_INIT = 0;
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d, 16'h0188)
    `CHK(USER_SIGNAL_N, 1'b1)
    // Two-word output with a slow memory, the last word ends by rollover
    host.mem[8'h80] = 16'ha5c3;
    host.mem[8'h81] = 16'h3c5a;
    slow = 1;
    reg_op(1, 2'h0, 2'h3, 16'hfffe);
    reg_op(1, 2'h1, 2'h3, 16'h0100);
    reg_op(1, 2'h2, 2'h1, 16'h0042);
    `WAITV(OUT_VALID, 1'b1)
    `CHK(OUT_DATA, 16'ha5c3)
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h0883, 16'h0802)
    OUT_ACCEPT = 1;
    `WAITV(OUT_VALID, 1'b0)
    OUT_ACCEPT = 0;
    `WAITV(OUT_VALID, 1'b1)
    `CHK(OUT_DATA, 16'h3c5a)
    `CHK(OUT_LAST, 1'b1)
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h8a83, 16'h0a00)
    `CHK(IRQ_REQ, 1'b0)
    reg_op(0, 2'h0, 2'h3, 0);
    `CHK(d, 16'h0000)
    reg_op(0, 2'h1, 2'h3, 0);
    `CHK(d, 16'h0104)
    OUT_ACCEPT = 1;
    `WAITV(IRQ_REQ, 1'b1)
    OUT_ACCEPT = 0;
    `CHK(IRQ_REQ, 1'b1)
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h8880, 16'h0080)
    grant_irq();
    `CHK(IRQ_REQ, 1'b0)
    // Word arriving with receive unarmed, then taken by an armed input
    slow = 0;
    reg_op(1, 2'h3, 2'h3, 16'h1234);
    reg_op(0, 2'h3, 2'h3, 0);
    `CHK(d, 16'h1234)
    IN_DATA = 16'h5aa5;
    IN_AVAIL = 1;
    repeat (10) @(posedge REF_CLK);
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'ha441, 16'ha440)
    `CHK(IRQ_REQ, 1'b1)
    grant_irq();
    reg_op(1, 2'h3, 2'h1, 16'h00ff);
    reg_op(0, 2'h3, 2'h3, 0);
    `CHK(d, 16'h5aa5)
    reg_op(1, 2'h0, 2'h3, 16'hffff);
    reg_op(1, 2'h1, 2'h3, 16'h0180);
    reg_op(1, 2'h2, 2'h1, 16'h0041);
    `WAITV(DMA_SYNC, 1'b1)
    `CHK(DMA_WRITE, 1'b1)
    `CHK(DMA_ADDR, 16'h0180)
    `CHK(DMA_WDATA, 16'h5aa5)
    `WAITV(DMA_SYNC, 1'b0)
    repeat (3) @(posedge REF_CLK);
    IN_AVAIL = 0;
    `CHK(host.mem[8'hc0], 16'h5aa5)
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h2401, 16'h0000)
    reg_op(1, 2'h2, 2'h2, 16'h0000);
    grant_irq();
    // Silent memory location during an output fetch
    mute = 1;
    reg_op(1, 2'h0, 2'h3, 16'hfffe);
    reg_op(1, 2'h2, 2'h1, 16'h0002);
    `WAITV(DMA_REQ, 1'b1)
    `CHK(DMA_WRITE, 1'b0)
    `CHK(DMA_ADDR, 16'h0182)
    `WAITV(DMA_SYNC, 1'b1)
    repeat (40) @(posedge REF_CLK);
    mute = 0;
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'hc003, 16'hc000)
    reg_op(1, 2'h2, 2'h1, 16'h0000);
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h4000, 16'h0000)
    // Early end of an input while the sense line is low
    SENSE_IN = 0;
    reg_op(1, 2'h0, 2'h3, 16'hfff0);
    reg_op(1, 2'h2, 2'h1, 16'h0001);
    EARLY_END = 1;
    repeat (10) @(posedge REF_CLK);
    EARLY_END = 0;
    reg_op(0, 2'h2, 2'h3, 0);
    `CHK(d & 16'h9009, 16'h9000)
    reg_op(0, 2'h0, 2'h3, 0);
    `CHK(d, 16'hfff0)
    tally_and_finish();
  end
endmodule : word_dma_interface_control_tb

// ===== src/in_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes inputs are independent levels; output follows once stages two and three agree.
`timescale 1ns/100ps
module in_sync
  #(parameter int W = 1)
  (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
  );
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } sync_state_t;
  sync_state_t q, d;
  always_comb
  begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // Per bit: a change counts only when stages two and three agree
    d.o = (q.s2 & q.s3) | (q.o & (q.s2 | q.s3));
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
  assign dout = q.o;
endmodule : in_sync

// ===== src/reply_timer.sv
// Counts reference clocks while a bus data cycle waits for its acknowledge.
// Assumes run stays high for the whole wait and drops when the cycle ends.
`timescale 1ns/100ps
`include "wdma_consts.svh"
module reply_timer
  import wdma_pkg::*;
  #(parameter int CYCLES = `REPLY_TMO_CYC)
  (
  input wire logic clk,
  input wire logic rst_n,
  tmo_if.cnt t
  );
  localparam logic [15:0] LAST = 16'(CYCLES - 1);
  tmo_state_t q, d;
  always_comb
  begin
    d = q;
    if (!t.run)
    begin
      d.cnt = '0;
      d.expired = 1'b0;
    end
    else if (q.cnt == LAST)
      d.expired = 1'b1;
    else
      d.cnt = q.cnt + 16'h0001;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
  assign t.expired = q.expired;
endmodule : reply_timer

// ===== src/tmo_if.sv
// Carrier between the controller and its reply timeout counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface tmo_if;
  logic run;
  logic expired;
  modport ctl (output run, input expired);
  modport cnt (input run, output expired);
endinterface : tmo_if

// ===== src/wdma_consts.svh
// Offsets, field positions, reset values and timing counts of the word DMA interface.
// Assumes inclusion by bare name from the reply timer and the top module.
`ifndef WDMA_CONSTS_SVH
`define WDMA_CONSTS_SVH
`define SEL_WORD_COUNTER 2'h0
`define SEL_BUS_ADDRESS 2'h1
`define SEL_CONTROL_STATUS 2'h2
`define SEL_DATA_BUFFER 2'h3
`define CS_RX_ARM 0
`define CS_TX_ARM 1
`define CS_USER_SIG 2
`define CS_SENSE 3
`define CS_IRQ_ALLOW 6
`define CS_IN_PRESENT 10
`define CS_OUT_PENDING 11
`define IRQ_LEVEL 3'h5
`define ADDR_STEP 16'h0002
`define REPLY_TMO_US 20
`define REF_CLK_MHZ 40
`define REPLY_TMO_CYC (`REPLY_TMO_US * `REF_CLK_MHZ)
`define SYNC_WIDTH 5
`endif

// ===== src/wdma_pkg.sv
// Types shared by the word DMA interface modules.
// Assumes the constants header sits beside it.
package wdma_pkg;
  typedef enum logic [1:0] {DS_IDLE, DS_REQ, DS_CYC, DS_REL} dma_state_t;
  typedef struct packed {
    logic [15:0] wc;
    logic [15:0] ba;
    logic [15:0] dbuf;
    logic rx;
    logic tx;
    logic user_sig;
    logic usig_n;
    logic allow;
    logic last_dir;
    logic final_w;
    logic in_pres;
    logic owp;
    logic oval;
    logic eef;
    logic nmr;
    logic roll_pend;
    logic irq;
    logic [2:0] irq_lvl;
    dma_state_t dma;
    logic req;
    logic sync;
    logic dwrite;
    logic [15:0] rdata;
    logic ack;
    logic p_avail;
    logic p_accept;
    logic p_eend;
    logic p_unarm;
  } ctl_state_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic expired;
  } tmo_state_t;
endpackage : wdma_pkg

// ===== src/word_dma_ctl.sv
// Control, status and DMA sequencing of the 16-bit word DMA interface.
// Assumes register port and bus grant are on REF_CLK; cable lines and reply are asynchronous.
`timescale 1ns/100ps
`include "wdma_consts.svh"
module word_dma_ctl
  import wdma_pkg::*;
  #(parameter int REPLY_CYCLES = `REPLY_TMO_CYC)
  (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic BUS_INIT,
  input wire logic [1:0] REG_SEL,
  input wire logic REG_RD,
  input wire logic REG_WR,
  input wire logic [1:0] REG_BE,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_ACK,
  output logic DMA_REQ,
  input wire logic DMA_GRANT,
  output logic DMA_SYNC,
  output logic DMA_WRITE,
  output logic [15:0] DMA_ADDR,
  output logic [15:0] DMA_WDATA,
  input wire logic [15:0] DMA_RDATA,
  input wire logic DMA_REPLY,
  output logic IRQ_REQ,
  output logic [2:0] IRQ_LEVEL,
  input wire logic IRQ_GRANT,
  input wire logic [15:0] IN_DATA,
  input wire logic IN_AVAIL,
  input wire logic OUT_ACCEPT,
  input wire logic EARLY_END,
  input wire logic SENSE_IN,
  output logic [15:0] OUT_DATA,
  output logic OUT_VALID,
  output logic OUT_LAST,
  output logic USER_SIGNAL_N
  );
  ctl_state_t q, d;
  logic [4:0] sync_o;
  logic s_avail, s_accept, s_eend, s_sense, s_reply;
  logic ready, unarmed, exc, word_done, roll, load, any_ev;
  logic [15:0] status_v;
  tmo_if tmo ();

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and reply timeout

  in_sync #(.W(`SYNC_WIDTH)) u_sync (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .din({DMA_REPLY, SENSE_IN, EARLY_END, OUT_ACCEPT, IN_AVAIL}),
    .dout(sync_o)
  );
  assign {s_reply, s_sense, s_eend, s_accept, s_avail} = sync_o;

  reply_timer #(.CYCLES(REPLY_CYCLES)) u_tmo (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .t(tmo.cnt)
  );
  assign tmo.run = (q.dma == DS_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    word_done = 1'b0;
    roll = 1'b0;
    load = 1'b0;
    any_ev = 1'b0;
    ready = !q.rx && !q.tx && !q.owp;
    unarmed = q.in_pres && !q.rx;
    exc = q.nmr || unarmed || q.eef || (q.roll_pend && !q.allow);
    // Bits four and five stay zero for future extended address
    status_v = {exc, q.nmr, unarmed, q.eef, q.owp, q.in_pres, q.final_w, q.last_dir,
      ready, q.allow, 2'b00, s_sense, q.user_sig, q.tx, q.rx};
    d.p_avail = s_avail;
    d.p_accept = s_accept;
    d.p_eend = s_eend;
    d.p_unarm = unarmed;
    if (REG_RD)
    begin
      d.ack = 1'b1;
      if (REG_SEL == `SEL_WORD_COUNTER)
        d.rdata = q.wc;
      else if (REG_SEL == `SEL_BUS_ADDRESS)
        d.rdata = q.ba;
      else if (REG_SEL == `SEL_CONTROL_STATUS)
        d.rdata = status_v;
      else
        d.rdata = q.dbuf;
    end
    // Software clears come first so that hardware sets below win the same cycle
    if (REG_WR)
    begin
      d.ack = 1'b1;
      if (REG_SEL == `SEL_WORD_COUNTER)
      begin
        if (REG_BE[0]) d.wc[7:0] = REG_WDATA[7:0];
        if (REG_BE[1]) d.wc[15:8] = REG_WDATA[15:8];
      end
      else if (REG_SEL == `SEL_BUS_ADDRESS)
      begin
        if (REG_BE[0]) d.ba[7:0] = REG_WDATA[7:0];
        if (REG_BE[1]) d.ba[15:8] = REG_WDATA[15:8];
      end
      else if (REG_SEL == `SEL_CONTROL_STATUS)
      begin
        if (REG_BE[0])
        begin
          d.rx = REG_WDATA[`CS_RX_ARM];
          d.tx = REG_WDATA[`CS_TX_ARM];
          d.user_sig = REG_WDATA[`CS_USER_SIG];
          d.allow = REG_WDATA[`CS_IRQ_ALLOW];
          d.nmr = 1'b0;
          d.eef = 1'b0;
          d.roll_pend = 1'b0;
        end
        // High byte flags can only be written to zero
        if (REG_BE[1] && !REG_WDATA[`CS_IN_PRESENT])
          d.in_pres = 1'b0;
        if (REG_BE[1] && !REG_WDATA[`CS_OUT_PENDING])
        begin
          d.owp = 1'b0;
          d.oval = 1'b0;
        end
      end
      else if (REG_BE == 2'b11)
        d.dbuf = REG_WDATA;
    end
    if (BUS_INIT)
    begin
      d.rx = 1'b0;
      d.tx = 1'b0;
      d.user_sig = 1'b0;
      d.allow = 1'b0;
      d.last_dir = 1'b1;
    end
    if (s_accept && !q.p_accept && q.oval)
    begin
      d.oval = 1'b0;
      d.owp = 1'b0;
      d.final_w = 1'b0;
    end
    // Pending rollover interrupt waits until both arms and the output pending flag are clear
    if (q.roll_pend && ready && q.allow)
    begin
      d.roll_pend = 1'b0;
      any_ev = 1'b1;
    end
    case (q.dma)
      DS_IDLE:
      begin
        if (q.tx && !q.oval && !q.owp)
        begin
          d.dma = DS_REQ;
          d.dwrite = 1'b0;
        end
        else if (q.rx && q.in_pres)
        begin
          d.dma = DS_REQ;
          d.dwrite = 1'b1;
        end
      end
      DS_REQ:
      begin
        if (!q.rx && !q.tx)
          d.dma = DS_IDLE;
        else if (DMA_GRANT)
        begin
          d.dma = DS_CYC;
          d.sync = 1'b1;
        end
      end
      DS_CYC:
      begin
        if (s_reply)
        begin
          d.sync = 1'b0;
          d.dma = DS_REL;
          word_done = 1'b1;
          d.wc = q.wc + 16'h0001;
          d.ba = q.ba + `ADDR_STEP;
          roll = (q.wc == 16'hffff);
          if (q.dwrite)
          begin
            d.in_pres = 1'b0;
            d.last_dir = 1'b0;
          end
          else
          begin
            d.dbuf = DMA_RDATA;
            load = 1'b1;
            d.oval = 1'b1;
            d.owp = 1'b1;
            d.last_dir = 1'b1;
          end
        end
        else if (tmo.expired)
        begin
          d.sync = 1'b0;
          d.dma = DS_REL;
          d.nmr = 1'b1;
          d.rx = 1'b0;
          d.tx = 1'b0;
          any_ev = 1'b1;
        end
      end
      default:
      begin
        if (!s_reply)
          d.dma = DS_IDLE;
      end
    endcase
    if (s_avail && !q.p_avail)
    begin
      d.dbuf = IN_DATA;
      load = 1'b1;
      d.in_pres = 1'b1;
    end
    if (roll || (s_eend && !q.p_eend))
    begin
      d.rx = 1'b0;
      d.tx = 1'b0;
      d.owp = 1'b1;
      d.final_w = 1'b1;
      d.roll_pend = 1'b1;
    end
    if (s_eend && !q.p_eend)
    begin
      d.eef = 1'b1;
      any_ev = 1'b1;
    end
    if (unarmed && !q.p_unarm)
      any_ev = 1'b1;
    d.req = (d.dma == DS_REQ);
    if (IRQ_GRANT || !q.allow)
      d.irq = 1'b0;
    if (any_ev && q.allow)
      d.irq = 1'b1;
    // Cable line is active low, kept in its own flop so the pin never sees a gate
    d.usig_n = !d.user_sig;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      q <= '0;
      q.irq_lvl <= `IRQ_LEVEL;
      q.usig_n <= 1'b1;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state flops

  assign REG_RDATA = q.rdata;
  assign REG_ACK = q.ack;
  assign DMA_REQ = q.req;
  assign DMA_SYNC = q.sync;
  assign DMA_WRITE = q.dwrite;
  assign DMA_ADDR = q.ba;
  assign DMA_WDATA = q.dbuf;
  assign IRQ_REQ = q.irq;
  assign IRQ_LEVEL = q.irq_lvl;
  assign OUT_DATA = q.dbuf;
  assign OUT_VALID = q.oval;
  assign OUT_LAST = q.final_w;
  assign USER_SIGNAL_N = q.usig_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence cs_read_s;
    REG_RD && (REG_SEL == `SEL_CONTROL_STATUS);
  endsequence
  sequence roll_s;
    roll && !BUS_INIT;
  endsequence

  sense_mirror_a: assert property (cs_read_s |=> REG_RDATA[3] == $past(s_sense))
    else $error("sense status bit does not follow the cable line");
  reserved_zero_a: assert property (cs_read_s |=> REG_RDATA[5:4] == 2'b00)
    else $error("reserved status bits read nonzero");
  init_usersig_a: assert property (BUS_INIT |=> USER_SIGNAL_N)
    else $error("bus reset left user signal active");
  init_allow_a: assert property (BUS_INIT |=> !q.allow)
    else $error("bus reset left interrupt allow set");
  ready_read_a: assert property (cs_read_s |=> REG_RDATA[7] == $past(ready))
    else $error("ready bit disagrees with arms and pending");
  reply_tmo_a: assert property ((tmo.expired && q.dma == DS_CYC && !s_reply) |=> q.nmr)
    else $error("reply timeout did not set no-reply flag");
  nmr_clear_a: assert property ((REG_WR && REG_SEL == `SEL_CONTROL_STATUS
    && REG_BE[0] && !(q.dma == DS_CYC && tmo.expired)) |=> !q.nmr)
    else $error("low byte write did not clear no-reply flag");
  word_only_a: assert property ((REG_WR && REG_SEL == `SEL_DATA_BUFFER
    && REG_BE != 2'b11 && !load) |=> $stable(q.dbuf))
    else $error("partial write changed the data buffer");
  irq_gate_a: assert property ($rose(IRQ_REQ) |->
    $past(q.allow) && IRQ_LEVEL == `IRQ_LEVEL)
    else $error("interrupt raised without allow or at wrong level");
  rollover_a: assert property (roll_s |=> !q.rx && !q.tx && q.owp && q.final_w)
    else $error("rollover did not clear arms or set pending");
  count_step_a: assert property (word_done |=> q.wc == $past(q.wc) + 16'h0001)
    else $error("word count did not step by one");
  valid_pend_a: assert property (OUT_VALID |-> q.owp)
    else $error("data valid without pending flag");
endmodule : word_dma_ctl
